// ### src/wdt_params.svh
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_ADDR_W 18
`define WDT_SERVICE_IDX 16'hffff
`define WDT_SERVICE_ADDR {`WDT_SERVICE_IDX, 2'b00}
`define WDT_CFG_ADDR 18'h00000
`define WDT_RSRC_ADDR 18'h00004
`define WDT_EV_STAT_ADDR 18'h00008
`define WDT_EV_CLR_ADDR 18'h0000c
`define WDT_EV_EN_ADDR 18'h00010
`define WDT_STATE_ADDR 18'h00014
`define WDT_CFG_RATE_BIT 0
`define WDT_CFG_DIS_BIT 1
`define WDT_CFG_RESET 2'h0
`define WDT_RSRC_BIT 0
`define WDT_EV_SERVICE 0
`define WDT_EV_RESET 1
`define WDT_EV_W 2
`define WDT_PRE_BITS 12
`define WDT_CNT_BITS 6
`define WDT_KEEP_BITS 4
`define WDT_PULSE_OSC 32
`define WDT_POR_OSC 4096
`endif

// ### src/wdt_pkg.sv
`include "wdt_params.svh"
package wdt_pkg;
   typedef enum logic [2:0] {
      WDT_ST_OFF = 3'b001,
      WDT_ST_RUN = 3'b010,
      WDT_ST_PULSE = 3'b100
   } wdt_state_t;

   typedef struct packed {
      logic [`WDT_PRE_BITS-1:0] pre;
      logic [`WDT_CNT_BITS-1:0] cnt;
   } wdt_cnt_state_t;

   typedef struct packed {
      wdt_state_t st;
      logic rate;
      logic dis;
      logic rsrc;
      logic [`WDT_EV_W-1:0] ev_stat;
      logic [`WDT_EV_W-1:0] ev_en;
      logic [$clog2(`WDT_PULSE_OSC)-1:0] pulse;
      logic [$clog2(`WDT_POR_OSC)-1:0] por;
      logic por_done;
      logic osc_q;
      logic [31:0] rdata;
   } wdt_top_state_t;
endpackage : wdt_pkg

// ### src/wdt_cnt_if.sv
`timescale 1ns/1ps
interface wdt_cnt_if;
   import wdt_pkg::*;
   logic tick;
   logic clr_all;
   logic clr_pre;
   logic clr_service;
   logic rate;
   logic overflow;
   wdt_cnt_state_t view;
   modport ctl (output tick, output clr_all, output clr_pre, output clr_service, output rate,
      input overflow, input view);
   modport cnt (input tick, input clr_all, input clr_pre, input clr_service, input rate,
      output overflow, output view);
endinterface : wdt_cnt_if

// ### src/wdt_sync.sv
`timescale 1ns/1ps
module wdt_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } wdt_sync_state_t;

   wdt_sync_state_t s;
   wdt_sync_state_t next_s;
   logic [W-1:0] agreed;

   // a level counts only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign agreed[i] = (s.s2[i] == s.s3[i]) ? s.s3[i] : s.q[i];
      end
   endgenerate

   always_comb begin
      next_s = s;
      next_s.s1 = async_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.q = agreed;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level_out = s.q;
endmodule : wdt_sync

// ### src/wdt_counter.sv
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_counter
   import wdt_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   wdt_cnt_if.cnt bus
);
   wdt_cnt_state_t s;
   wdt_cnt_state_t next_s;
   logic carry;

   assign carry = bus.tick & (&s.pre);
   // fast rate overflows on the second carry, slow rate after the full 6-bit count
   assign bus.overflow = carry & (bus.rate ? s.cnt[0] : (&s.cnt));
   assign bus.view = s;

   always_comb begin
      next_s = s;
      if (bus.tick) begin
         next_s.pre = s.pre + 1'b1;
         if (carry) begin
            next_s.cnt = s.cnt + 1'b1;
         end
      end
      if (bus.clr_service) begin
         // low stages survive, hence up to 2^4-1 ticks short of a full period
         next_s.cnt = '0;
         next_s.pre[`WDT_PRE_BITS-1:`WDT_KEEP_BITS] = '0;
      end
      if (bus.clr_pre) begin
         next_s.pre = '0;
      end
      if (bus.clr_all) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule : wdt_counter

// ### src/wdt_reset_timer.sv
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_reset_timer
   import wdt_pkg::*;
(
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [`WDT_ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic OSC_CLK_IN,
   input wire logic STOP_IN,
   input wire logic STOP_MODE_IN,
   input wire logic INTERNAL_RST_IN,
   input wire logic VECTOR_FETCH_IN,
   input wire logic [7:0] RESET_VECTOR_LOW_IN,
   input wire logic MONITOR_MODE_IN,
   input wire logic BREAK_STATE_IN,
   input wire logic TST_ON_RST_IN,
   input wire logic TST_ON_IRQ_IN,
   output logic RST_PIN_OUT,
   output logic RST_PIN_OE_OUT,
   output logic WDT_SYS_RESET_OUT,
   output logic EVENT_IRQ_OUT
);
   localparam int PULSE_W = $clog2(`WDT_PULSE_OSC);
   localparam int POR_W = $clog2(`WDT_POR_OSC);
   localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(`WDT_PULSE_OSC - 1);
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(`WDT_POR_OSC - 1);

   wdt_top_state_t s;
   wdt_top_state_t next_s;

   logic [2:0] pin_level;
   logic osc_level;
   logic tst_rst;
   logic tst_irq;
   logic osc_tick;
   logic cnt_tick;
   logic disabled;
   logic por_fire;
   logic setup_ph;
   logic access_wr;
   logic access_ph;
   logic sel_service;
   logic sel_cfg;
   logic sel_rsrc;
   logic sel_ev_stat;
   logic sel_ev_clr;
   logic sel_ev_en;
   logic sel_state;
   logic mapped;
   logic service_wr;
   logic [31:0] rd_word;
   logic [`WDT_EV_W-1:0] ev_set;
   logic [`WDT_EV_W-1:0] ev_clr;

   wdt_cnt_if cnt_bus ();

   // oscillator and test-voltage detectors are asynchronous to the bus clock
   wdt_sync #(
      .W(3)
   ) u_sync (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .async_in({TST_ON_IRQ_IN, TST_ON_RST_IN, OSC_CLK_IN}),
      .level_out(pin_level)
   );

   assign osc_level = pin_level[0];
   assign tst_rst = pin_level[1];
   assign tst_irq = pin_level[2];

   // one pulse per oscillator period; the oscillator must stay well below half the bus clock
   assign osc_tick = osc_level & ~s.osc_q;
   assign cnt_tick = osc_tick & ~STOP_MODE_IN;

   assign disabled = s.dis
      | (MONITOR_MODE_IN & (tst_rst | tst_irq))
      | (BREAK_STATE_IN & tst_rst);

   assign por_fire = osc_tick & ~s.por_done & (s.por == POR_LAST);

   wdt_counter u_counter (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .bus(cnt_bus.cnt)
   );

   assign cnt_bus.tick = cnt_tick;
   assign cnt_bus.rate = s.rate;
   assign cnt_bus.clr_service = service_wr;
   assign cnt_bus.clr_pre = STOP_IN | VECTOR_FETCH_IN | por_fire;
   // counting only in the run state keeps a disabled or resetting watchdog cleared
   assign cnt_bus.clr_all = INTERNAL_RST_IN | (s.st != WDT_ST_RUN);

   // bus decode
   assign setup_ph = PSEL_IN & ~PENABLE_IN;
   assign access_ph = PSEL_IN & PENABLE_IN;
   assign access_wr = access_ph & PWRITE_IN;

   always_comb begin
      sel_service = 1'b0;
      sel_cfg = 1'b0;
      sel_rsrc = 1'b0;
      sel_ev_stat = 1'b0;
      sel_ev_clr = 1'b0;
      sel_ev_en = 1'b0;
      sel_state = 1'b0;
      if (PADDR_IN == `WDT_SERVICE_ADDR) begin
         sel_service = 1'b1;
      end else if (PADDR_IN == `WDT_CFG_ADDR) begin
         sel_cfg = 1'b1;
      end else if (PADDR_IN == `WDT_RSRC_ADDR) begin
         sel_rsrc = 1'b1;
      end else if (PADDR_IN == `WDT_EV_STAT_ADDR) begin
         sel_ev_stat = 1'b1;
      end else if (PADDR_IN == `WDT_EV_CLR_ADDR) begin
         sel_ev_clr = 1'b1;
      end else if (PADDR_IN == `WDT_EV_EN_ADDR) begin
         sel_ev_en = 1'b1;
      end else if (PADDR_IN == `WDT_STATE_ADDR) begin
         sel_state = 1'b1;
      end
   end

   assign mapped = sel_service | sel_cfg | sel_rsrc | sel_ev_stat | sel_ev_clr | sel_ev_en | sel_state;
   assign service_wr = access_wr & sel_service;

   always_comb begin
      rd_word = '0;
      if (sel_service) begin
         rd_word[7:0] = RESET_VECTOR_LOW_IN;
      end else if (sel_cfg) begin
         rd_word[`WDT_CFG_RATE_BIT] = s.rate;
         rd_word[`WDT_CFG_DIS_BIT] = s.dis;
      end else if (sel_rsrc) begin
         rd_word[`WDT_RSRC_BIT] = s.rsrc;
      end else if (sel_ev_stat) begin
         rd_word[`WDT_EV_W-1:0] = s.ev_stat;
      end else if (sel_ev_en) begin
         rd_word[`WDT_EV_W-1:0] = s.ev_en;
      end else if (sel_state) begin
         rd_word[`WDT_PRE_BITS-1:0] = cnt_bus.view.pre;
         rd_word[16 +: `WDT_CNT_BITS] = cnt_bus.view.cnt;
         rd_word[24 +: 3] = s.st;
      end
   end

   // event sources and software clear
   always_comb begin
      ev_set = '0;
      ev_set[`WDT_EV_SERVICE] = service_wr;
      ev_set[`WDT_EV_RESET] = (s.st == WDT_ST_RUN) & cnt_bus.overflow & ~disabled;
      ev_clr = '0;
      if (access_wr & sel_ev_clr) begin
         ev_clr = PWDATA_IN[`WDT_EV_W-1:0];
      end
   end

   always_comb begin
      next_s = s;
      next_s.osc_q = osc_level;
      if (setup_ph) begin
         next_s.rdata = rd_word;
      end
      if (osc_tick & ~s.por_done) begin
         next_s.por = s.por + 1'b1;
         if (s.por == POR_LAST) begin
            next_s.por_done = 1'b1;
         end
      end
      if (access_wr & sel_cfg) begin
         next_s.rate = PWDATA_IN[`WDT_CFG_RATE_BIT];
         next_s.dis = PWDATA_IN[`WDT_CFG_DIS_BIT];
      end
      if (access_wr & sel_ev_en) begin
         next_s.ev_en = PWDATA_IN[`WDT_EV_W-1:0];
      end
      // a set in the same cycle as its clear wins
      next_s.ev_stat = (s.ev_stat & ~ev_clr) | ev_set;
      if (access_wr & sel_rsrc & PWDATA_IN[`WDT_RSRC_BIT]) begin
         next_s.rsrc = 1'b0;
      end
      case (s.st)
         WDT_ST_OFF: begin
            if (~disabled) begin
               next_s.st = WDT_ST_RUN;
            end
         end
         WDT_ST_RUN: begin
            if (disabled) begin
               next_s.st = WDT_ST_OFF;
            end else if (cnt_bus.overflow) begin
               // overflow resets and also sets the reset event, which interrupts the cpu when enabled
               next_s.st = WDT_ST_PULSE;
               next_s.pulse = '0;
               next_s.rsrc = 1'b1;
            end
         end
         WDT_ST_PULSE: begin
            // the pulse runs to its end even if disabled meanwhile
            if (osc_tick) begin
               next_s.pulse = s.pulse + 1'b1;
               if (s.pulse == PULSE_LAST) begin
                  next_s.st = WDT_ST_OFF;
               end
            end
         end
         default: begin
            next_s.st = WDT_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         s <= '0;
         s.st <= WDT_ST_OFF;
         s.rate <= 1'(`WDT_CFG_RESET >> `WDT_CFG_RATE_BIT);
         s.dis <= 1'(`WDT_CFG_RESET >> `WDT_CFG_DIS_BIT);
      end else begin
         s <= next_s;
      end
   end

   // zero wait states: data captured in setup, presented in access
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = access_ph & ~mapped;
   assign PRDATA_OUT = s.rdata;
   // open-drain reset pin: only ever pulled low
   assign RST_PIN_OUT = 1'b0;
   assign RST_PIN_OE_OUT = (s.st == WDT_ST_PULSE);
   assign WDT_SYS_RESET_OUT = (s.st == WDT_ST_PULSE);
   assign EVENT_IRQ_OUT = |(s.ev_stat & s.ev_en);
endmodule : wdt_reset_timer

// ### sim/wdt_far_model.sv
`timescale 1ns/1ps
module wdt_far_model (
   output logic osc_clk_out,
   input wire logic rst_pin_in,
   input wire logic rst_pin_oe_in,
   output logic rst_level_out
);
   // free-running oscillator, 8 bus clocks a cycle to keep runs short
   initial begin
      osc_clk_out = 1'b0;
      #37;
      forever #400 osc_clk_out = ~osc_clk_out;
   end
   // open-drain reset line, pulled up when released
   assign rst_level_out = rst_pin_oe_in ? rst_pin_in : 1'b1;
endmodule : wdt_far_model

// ### sim/wdt_reset_timer_asserts.sv
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_reset_timer_chk (
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [`WDT_ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic OSC_CLK_IN,
   input wire logic STOP_MODE_IN,
   input wire logic INTERNAL_RST_IN,
   input wire logic [7:0] RESET_VECTOR_LOW_IN,
   input wire logic MONITOR_MODE_IN,
   input wire logic BREAK_STATE_IN,
   input wire logic TST_ON_RST_IN,
   input wire logic TST_ON_IRQ_IN,
   input wire logic RST_PIN_OUT,
   input wire logic RST_PIN_OE_OUT,
   input wire logic WDT_SYS_RESET_OUT
);
   logic osc_q;
   logic [5:0] ticks;
   // raw oscillator rises seen while the reset pulse stands
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         osc_q <= 1'b0;
         ticks <= 6'h00;
      end else begin
         osc_q <= OSC_CLK_IN;
         if (!WDT_SYS_RESET_OUT)
            ticks <= 6'h00;
         else if (OSC_CLK_IN && !osc_q)
            ticks <= ticks + 6'h01;
      end
   end
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (SYS_RST_IN);
   // 8 cycles covers the pin synchronisers
   sequence s_held(logic c);
      c [*8];
   endsequence
   sequence s_rd_svc;
      PSEL_IN && PENABLE_IN && !PWRITE_IN && PADDR_IN == `WDT_SERVICE_ADDR;
   endsequence
   a_pin_follows: assert property (RST_PIN_OE_OUT == WDT_SYS_RESET_OUT)
      else $error("pin enable differs from reset");
   a_pin_low: assert property (RST_PIN_OE_OUT |-> !RST_PIN_OUT)
      else $error("pin not driven low");
   a_pulse_len: assert property ($fell(WDT_SYS_RESET_OUT) |-> ticks inside {[31:33]})
      else $error("reset pulse length wrong");
   a_mon_irq: assert property (s_held(MONITOR_MODE_IN && TST_ON_IRQ_IN) |-> !$rose(WDT_SYS_RESET_OUT))
      else $error("reset while off by irq pin");
   a_mon_rst: assert property (s_held(MONITOR_MODE_IN && TST_ON_RST_IN) |-> !$rose(WDT_SYS_RESET_OUT))
      else $error("reset while off by reset pin");
   a_brk_rst: assert property (s_held(BREAK_STATE_IN && TST_ON_RST_IN) |-> !$rose(WDT_SYS_RESET_OUT))
      else $error("reset while off in break");
   a_int_clear: assert property (s_held(INTERNAL_RST_IN) |-> !$rose(WDT_SYS_RESET_OUT))
      else $error("reset during internal reset");
   a_stop_gate: assert property (s_held(STOP_MODE_IN) |-> !$rose(WDT_SYS_RESET_OUT))
      else $error("reset in stop mode");
   a_read_vec: assert property (s_rd_svc |-> PRDATA_OUT == {24'h0, $past(RESET_VECTOR_LOW_IN)})
      else $error("service read not vector");
endmodule : wdt_reset_timer_chk
bind wdt_reset_timer wdt_reset_timer_chk u_wdt_reset_timer_chk (.CLOCK_IN, .SYS_RST_IN, .PSEL_IN,
   .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PRDATA_OUT, .OSC_CLK_IN, .STOP_MODE_IN, .INTERNAL_RST_IN,
   .RESET_VECTOR_LOW_IN, .MONITOR_MODE_IN, .BREAK_STATE_IN, .TST_ON_RST_IN, .TST_ON_IRQ_IN,
   .RST_PIN_OUT, .RST_PIN_OE_OUT, .WDT_SYS_RESET_OUT);

// ### sim/wdt_reset_timer_tb.sv
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_reset_timer_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, stop, stop_mode, int_rst, vfetch, mon, brk, tst_rst, tst_irq;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] vec;
   logic pready, pslverr, err, osc, pin, pin_oe, sys_rst, irq, rst_level;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   wdt_far_model u_wdt_far_model (.osc_clk_out(osc), .rst_pin_in(pin), .rst_pin_oe_in(pin_oe),
      .rst_level_out(rst_level));
   wdt_reset_timer u_wdt_reset_timer (.CLOCK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OSC_CLK_IN(osc),
      .STOP_IN(stop), .STOP_MODE_IN(stop_mode), .INTERNAL_RST_IN(int_rst), .VECTOR_FETCH_IN(vfetch),
      .RESET_VECTOR_LOW_IN(vec), .MONITOR_MODE_IN(mon), .BREAK_STATE_IN(brk), .TST_ON_RST_IN(tst_rst),
      .TST_ON_IRQ_IN(tst_irq), .RST_PIN_OUT(pin), .RST_PIN_OE_OUT(pin_oe),
      .WDT_SYS_RESET_OUT(sys_rst), .EVENT_IRQ_OUT(irq));
   task close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         failures = failures + 1;
         close_out();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   task apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [17:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rdr(input logic [17:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rdr
   task t_regs;
      rdr(`WDT_CFG_ADDR);
      check(rd, 32'h0);
      vec <= 8'ha5;
      rdr(`WDT_SERVICE_ADDR);
      check(rd, 32'h000000a5);
      vec <= 8'h3c;
      rdr(`WDT_SERVICE_ADDR);
      check(rd, 32'h0000003c);
      rdr(18'h00100);
      check({rd[30:0], err}, 32'h1);
   endtask : t_regs
   task t_service;
      idle(300);
      wr(`WDT_SERVICE_ADDR, 32'hffffffff);
      rdr(`WDT_STATE_ADDR);
      check({rd[21:16], rd[11:4]}, 32'h0);
      wr(`WDT_EV_EN_ADDR, 32'h1);
      idle(1);
      check(irq, 1'b1);
      wr(`WDT_EV_EN_ADDR, 32'h0);
      idle(1);
      check(irq, 1'b0);
      wr(`WDT_EV_EN_ADDR, 32'h1);
      wr(`WDT_EV_CLR_ADDR, 32'h1);
      idle(1);
      check(irq, 1'b0);
   endtask : t_service
   task t_clears;
      for (int i = 0; i < 3; i++) begin
         idle(400);
         {vfetch, int_rst, stop} <= 3'b001 << i;
         idle(i == 2 ? 10 : 1);
         {stop, vfetch, int_rst} <= 3'b000;
         rdr(`WDT_STATE_ADDR);
         check(rd[11:0] < 12'h004, 1'b1);
      end
   endtask : t_clears
   task t_stop_mode;
      logic [11:0] s;
      stop_mode <= 1'b1;
      idle(10);
      rdr(`WDT_STATE_ADDR);
      s = rd[11:0];
      idle(100);
      rdr(`WDT_STATE_ADDR);
      check(rd[11:0], s);
      stop_mode <= 1'b0;
   endtask : t_stop_mode
   task t_disable;
      for (int i = 0; i < 4; i++) begin
         if (i == 0)
            wr(`WDT_CFG_ADDR, 32'h2);
         else
            {mon, brk, tst_rst, tst_irq} <= (i == 1) ? 4'b1001 : (i == 2) ? 4'b1010 : 4'b0110;
         idle(200);
         rdr(`WDT_STATE_ADDR);
         check(rd[21:0], 32'h0);
         wr(`WDT_CFG_ADDR, 32'h0);
         {mon, brk, tst_rst, tst_irq} <= 4'h0;
         idle(20);
      end
   endtask : t_disable
   task t_por;
      logic [11:0] prev;
      // fresh service so no prescaler wrap lands before the power-on clear
      wr(`WDT_SERVICE_ADDR, 32'h0);
      prev = 12'h0;
      rdr(`WDT_STATE_ADDR);
      while (rd[11:0] >= prev) begin
         prev = rd[11:0];
         rdr(`WDT_STATE_ADDR);
      end
      check(cycles > 32740 && cycles < 32830, 1'b1);
   endtask : t_por
   task t_overflow;
      int t0;
      wr(`WDT_CFG_ADDR, 32'h1);
      wr(`WDT_SERVICE_ADDR, 32'h0);
      t0 = cycles;
      while (sys_rst !== 1'b1) @(posedge clk);
      check(cycles - t0 > 65380 && cycles - t0 < 65560, 1'b1);
      idle(2);
      check(rst_level, 1'b0);
      t0 = cycles;
      while (sys_rst !== 1'b0) @(posedge clk);
      check(cycles - t0 > 240 && cycles - t0 < 272, 1'b1);
      rdr(`WDT_RSRC_ADDR);
      check(rd, 32'h1);
      rdr(`WDT_EV_STAT_ADDR);
      check(rd & 32'h2, 32'h2);
   endtask : t_overflow
   initial begin
      {psel, penable, pwrite, stop, stop_mode, int_rst, vfetch, mon, brk, tst_rst, tst_irq} = '0;
      paddr = 18'h0;
      pwdata = 32'h0;
      vec = 8'h00;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wr(`WDT_SERVICE_ADDR, 32'h0);
      t_regs();
      t_service();
      t_clears();
      t_stop_mode();
      t_disable();
      t_por();
      t_overflow();
      close_out();
   end
endmodule : wdt_reset_timer_tb
